// ### core/ets_pkg.sv
// package: constants and types for error and thermal sideband signalling
package ets_pkg;
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned MCHK_PULSE_CYC   = 16;
  localparam int unsigned TOGGLE_WIN_US10  = 15;  // 1.5 ms in units of 100 us
  localparam int unsigned TOGGLE_WIN_CYC   = (CLK_HZ / 10_000) * TOGGLE_WIN_US10;
  localparam int unsigned CNT_W            = 17;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 17'h00000;
  localparam logic [4:0]  PULSE_LAST       = 5'h0F;

  typedef enum logic [1:0] {FF_IDLE, FF_PULSE, FF_HOLD} ets_fault_st_t;

  typedef struct packed {
    logic machineCheckFault;
    logic internalFault;
    logic warmReset;
    logic coldReset;
    logic tempAtMax;
    logic tempTrip;
    logic throttleEnable;
  } ets_events_t;

  typedef struct packed {
    ets_fault_st_t    faultSt;
    logic [4:0]       pulseCnt;
    logic             fatalFault;
    logic             alertDrive;
    logic             alertSeen;
    logic             toggleArmed;
    logic [CNT_W-1:0] winCnt;
    logic             lowestPerfState;
    logic             throttle;
    logic             shutdown;
  } ets_state_t;
endpackage : ets_pkg

// ### core/ets_error_thermal.sv
// module: catastrophic error, overtemperature alert and thermal shutdown logic
`timescale 1ns/1ps
module ets_error_thermal #(
  parameter int unsigned TOGGLE_WIN = ets_pkg::TOGGLE_WIN_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire ets_pkg::ets_events_t events,
  input  wire logic               overtempAlertIn,
  output logic                    overtempAlertOut,
  output logic                    overtempAlertOe,
  output logic                    fatalFault_n,
  output logic                    thermalShutdown_n,
  output logic                    execHalt,
  output logic                    thermalThrottleCircuit,
  output logic                    lowestPerfState
);
  ets_pkg::ets_state_t st_q;
  ets_pkg::ets_state_t st_d;
  logic alertLevel;

  // warm or cold reset request seen this cycle
  function automatic logic anyReset(input ets_pkg::ets_events_t ev);
    anyReset = ev.warmReset || ev.coldReset;
  endfunction : anyReset

  assign alertLevel = !overtempAlertIn;

  always_comb begin
    st_d = st_q;
    case (st_q.faultSt)
      ets_pkg::FF_IDLE: begin
        if (events.internalFault) begin
          st_d.faultSt = ets_pkg::FF_HOLD;
        end else if (events.machineCheckFault) begin
          st_d.faultSt  = ets_pkg::FF_PULSE;
          st_d.pulseCnt = 5'h00;
        end
      end
      ets_pkg::FF_PULSE: begin
        st_d.pulseCnt = st_q.pulseCnt + 5'h01;
        if (events.internalFault) begin
          st_d.faultSt = ets_pkg::FF_HOLD;
        end else if (st_q.pulseCnt == ets_pkg::PULSE_LAST) begin
          st_d.faultSt = ets_pkg::FF_IDLE;
        end
      end
      ets_pkg::FF_HOLD: begin
        if (anyReset(events)) begin
          st_d.faultSt = ets_pkg::FF_IDLE;
        end
      end
      default: st_d.faultSt = ets_pkg::FF_IDLE;
    endcase
    st_d.fatalFault = (st_d.faultSt != ets_pkg::FF_IDLE);
    st_d.alertDrive = events.tempAtMax;
    st_d.alertSeen  = alertLevel;
    // toggle lockout: second edge within the window
    if (st_q.winCnt != ets_pkg::CNT_ZERO) begin
      st_d.winCnt = st_q.winCnt - 17'h00001;
    end else begin
      st_d.toggleArmed = 1'b0;
    end
    if (alertLevel != st_q.alertSeen) begin
      if (st_q.toggleArmed && st_q.winCnt != ets_pkg::CNT_ZERO) begin
        st_d.lowestPerfState = 1'b1;
      end
      st_d.toggleArmed = 1'b1;
      st_d.winCnt      = TOGGLE_WIN[ets_pkg::CNT_W-1:0];
    end
    // reset request releases the performance lock
    if (anyReset(events)) begin
      st_d.lowestPerfState = 1'b0;
    end
    st_d.throttle = events.throttleEnable && (events.tempAtMax || alertLevel);
    if (events.tempTrip) begin
      st_d.shutdown = 1'b1;
    end else if (events.coldReset) begin
      st_d.shutdown = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fatalFault_n           = !st_q.fatalFault;
  assign overtempAlertOut       = 1'b0;
  assign overtempAlertOe        = st_q.alertDrive;
  assign thermalShutdown_n      = !st_q.shutdown;
  assign execHalt               = st_q.shutdown;
  assign thermalThrottleCircuit = st_q.throttle;
  assign lowestPerfState        = st_q.lowestPerfState;

  // machine check pulse accepted from idle
  sequence s_mchk_start;
    (st_q.faultSt == ets_pkg::FF_IDLE) && events.machineCheckFault && !events.internalFault;
  endsequence

  // sixteen cycles of fatal fault low
  sequence s_pulse_body;
    !fatalFault_n [*8] ##1 !fatalFault_n [*8];
  endsequence

  // last cycle of the pulse with no escalation
  sequence s_pulse_last;
    (st_q.faultSt == ets_pkg::FF_PULSE) && (st_q.pulseCnt == ets_pkg::PULSE_LAST) && !events.internalFault;
  endsequence

  // held fault meets a reset request
  sequence s_hold_cleared;
    (st_q.faultSt == ets_pkg::FF_HOLD) && anyReset(events);
  endsequence

  // second alert edge inside an armed window
  sequence s_toggle_fast;
    (alertLevel != st_q.alertSeen) && st_q.toggleArmed && (st_q.winCnt != ets_pkg::CNT_ZERO);
  endsequence

  a_mchk_pulse_len: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_mchk_start
    |=> s_pulse_body)
    else $error("machine check pulse shorter than 16 cycles");

  a_mchk_pulse_run: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_pulse_last
    |=> fatalFault_n)
    else $error("machine check pulse longer than 16 cycles");

  a_internal_fault_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_q.faultSt == ets_pkg::FF_HOLD) && !events.warmReset && !events.coldReset
    |=> !fatalFault_n)
    else $error("internal fault released early");

  a_hold_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_hold_cleared
    |=> fatalFault_n)
    else $error("held fault not released by reset");

  a_fault_assert: assert property (@(posedge core_clk) disable iff (!arst_n)
    events.internalFault
    |=> !fatalFault_n)
    else $error("fatal fault not asserted");

  a_idle_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_q.faultSt == ets_pkg::FF_IDLE) && !events.machineCheckFault && !events.internalFault
    |=> fatalFault_n)
    else $error("fatal fault asserted without a fault");

  a_alert_drive: assert property (@(posedge core_clk) disable iff (!arst_n)
    events.tempAtMax
    |=> overtempAlertOe && !overtempAlertOut)
    else $error("alert not driven at max temperature");

  a_alert_release: assert property (@(posedge core_clk) disable iff (!arst_n)
    !events.tempAtMax
    |=> !overtempAlertOe)
    else $error("alert driven below max temperature");

  a_max_throttle: assert property (@(posedge core_clk) disable iff (!arst_n)
    events.tempAtMax && events.throttleEnable
    |=> thermalThrottleCircuit)
    else $error("max temperature did not throttle");

  a_throttle_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
    !events.throttleEnable
    |=> !thermalThrottleCircuit)
    else $error("throttle active while disabled");

  a_ext_throttle: assert property (@(posedge core_clk) disable iff (!arst_n)
    !overtempAlertIn && events.throttleEnable
    |=> thermalThrottleCircuit)
    else $error("external alert did not throttle");

  a_toggle_lock: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_toggle_fast ##0 (!events.warmReset && !events.coldReset)
    |=> lowestPerfState)
    else $error("rapid toggle did not lock performance state");

  a_lock_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    lowestPerfState && !anyReset(events)
    |=> lowestPerfState)
    else $error("performance lock dropped without reset");

  a_lock_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    anyReset(events)
    |=> !lowestPerfState)
    else $error("performance lock kept across reset");

  a_trip_shutdown: assert property (@(posedge core_clk) disable iff (!arst_n)
    events.tempTrip
    |=> !thermalShutdown_n && execHalt)
    else $error("thermal trip not signalled");

  a_trip_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    !thermalShutdown_n && !events.coldReset
    |=> !thermalShutdown_n)
    else $error("shutdown released without cold reset");

  a_halt_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    execHalt && !events.coldReset
    |=> execHalt)
    else $error("halt released without cold reset");

  a_cold_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    events.coldReset && !events.tempTrip
    |=> thermalShutdown_n && !execHalt)
    else $error("cold reset did not clear shutdown");

endmodule : ets_error_thermal

// ### verif/ets_platform_model.sv
// platform model: pulled-up open-drain alert wire
`timescale 1ns/1ps
module ets_platform_model (
  input  wire logic devOe,
  input  wire logic extAssert,
  output logic      alertWire
);
  assign alertWire = !(devOe || extAssert);
endmodule : ets_platform_model

// ### verif/error_thermal_signaling_test.sv
// testbench: fault, alert and shutdown scenarios
`timescale 1ns/1ps
module error_thermal_signaling_test;
  localparam int unsigned WIN = 20;
  logic                 clk, arst_n, ext, pin, oe, aOut, ffN, tsN, halt, thr, lps;
  ets_pkg::ets_events_t ev;
  int                   failures = 0;
  int                   testsRun = 0;
  ets_error_thermal #(.TOGGLE_WIN(WIN)) u_ets_error_thermal (.core_clk(clk), .arst_n(arst_n), .events(ev),
    .overtempAlertIn(pin), .overtempAlertOut(aOut), .overtempAlertOe(oe), .fatalFault_n(ffN),
    .thermalShutdown_n(tsN), .execHalt(halt), .thermalThrottleCircuit(thr), .lowestPerfState(lps));
  ets_platform_model u_ets_platform_model (.devOe(oe), .extAssert(ext), .alertWire(pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic seen, input logic exp, input string msg);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic conclude;
    $display("failures=%0d tests_run=%0d", failures, testsRun);
    if (failures == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic mchk;
    ev.machineCheckFault = 1'b1;
    step(1);
    ev.machineCheckFault = 1'b0;
    check(ffN, 1'b0, "pulse start");
    step(15);
    check(ffN, 1'b0, "pulse cycle 16");
    step(1);
    check(ffN, 1'b1, "pulse end");
  endtask : mchk
  task automatic internal_fault;
    ev.internalFault = 1'b1;
    step(1);
    ev.internalFault = 1'b0;
    step(40);
    check(ffN, 1'b0, "hold");
    ev.warmReset = 1'b1;
    step(1);
    ev.warmReset = 1'b0;
    check(ffN, 1'b1, "hold cleared");
  endtask : internal_fault
  task automatic hot;
    ev.tempAtMax = 1'b1;
    step(1);
    check(pin, 1'b0, "alert driven");
    check(aOut, 1'b0, "alert drives low");
    check(thr, 1'b1, "throttle");
    step(30);
    ev.tempAtMax = 1'b0;
    step(30);
    check(lps, 1'b0, "slow toggles");
    ext = 1'b1;
    step(1);
    check(thr, 1'b1, "external throttle");
    step(5);
    ext = 1'b0;
    step(2);
    check(lps, 1'b1, "fast toggles");
    ev.warmReset = 1'b1;
    step(1);
    ev.warmReset = 1'b0;
    check(lps, 1'b0, "lock cleared");
    ev.throttleEnable = 1'b0;
    ev.tempAtMax = 1'b1;
    step(1);
    ev.tempAtMax = 1'b0;
    check(pin, 1'b0, "alert without throttle");
    check(thr, 1'b0, "throttle disabled");
    ev.throttleEnable = 1'b1;
    step(1);
  endtask : hot
  task automatic trip;
    ev.tempTrip = 1'b1;
    step(1);
    ev.tempTrip = 1'b0;
    check(tsN, 1'b0, "shutdown");
    check(halt, 1'b1, "halt");
    ev.warmReset = 1'b1;
    step(10);
    ev.warmReset = 1'b0;
    check(tsN, 1'b0, "sticky");
    ev.coldReset = 1'b1;
    step(1);
    ev.coldReset = 1'b0;
    check(tsN, 1'b1, "cold reset");
  endtask : trip
  initial begin
    #20000;
    failures++;
    conclude();
  end
  initial begin
    arst_n = 1'b0;
    ext = 1'b0;
    ev = '0;
    ev.throttleEnable = 1'b1;
    step(20);
    arst_n = 1'b1;
    check(ffN, 1'b1, "reset fatal");
    mchk();
    internal_fault();
    hot();
    trip();
    conclude();
  end
endmodule : error_thermal_signaling_test
